/* File: hw/external_interrupt_sources.sv */
// external interrupt request logic with a wishbone register slave
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module external_interrupt_sources
  import ext_irq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic nmiPin,
  input wire logic [NUM_IRQ-1:0] irqPin_n,
  input wire logic intMaskBit,
  input wire logic standbyIn,
  input wire logic nmiAck,
  output logic nmiReq,
  output logic [7:0] nmiVector,
  output logic [NUM_IRQ-1:0] irqReq,
  output logic [3:0] irqPriority,
  output logic wakeUp,
  output logic intOut
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic [6:0] s3_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end
    else
    begin
      s1_r <= {nmiPin, irqPin_n};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // edge detection waits until the last stage holds a real pin sample
  logic [2:0] primed_r;
  logic primed;

  always_ff @(posedge clk)
  begin
    if (srst)
      primed_r <= 3'h0;
    else
      primed_r <= {primed_r[1:0], 1'b1};
  end

  assign primed = primed_r[2];

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  ctrl_t ctrl_r;
  logic [NUM_IRQ-1:0] flags_r;
  logic [7:0] evt_r;
  logic [7:0] evtMask_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic wrEn;
  logic rdEn;

  assign wrEn = cyc_i & stb_i & we_i & ack_r & sel_i[0];
  assign rdEn = cyc_i & stb_i & ~ack_r;
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  always_ff @(posedge clk)
  begin
    if (srst)
      ack_r <= 1'b0;
    else
      ack_r <= cyc_i & stb_i & ~ack_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dat_r <= 32'h0000_0000;
    else if (rdEn)
    begin
      dat_r <= 32'h0000_0000;
      if (adr_i == ADR_SYSCTL)
        dat_r[0] <= ctrl_r.nmiEdge;
      else if (adr_i == ADR_SENSE)
        dat_r[5:0] <= ctrl_r.sense;
      else if (adr_i == ADR_ENABLE)
        dat_r[5:0] <= ctrl_r.enable;
      else if (adr_i == ADR_FLAGS)
        dat_r[5:0] <= flags_r;
      else if (adr_i == ADR_PRIO)
        dat_r[PRIO_MSB:PRIO_LSB] <= ctrl_r.prio;
      else if (adr_i == ADR_EVT)
        dat_r[7:0] <= evt_r;
      else if (adr_i == ADR_EVTMASK)
        dat_r[7:0] <= evtMask_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r.nmiEdge <= NMI_EDGE_RST;
      ctrl_r.sense <= SENSE_RST;
      ctrl_r.enable <= ENABLE_RST;
      ctrl_r.prio <= PRIO_RST;
      evtMask_r <= EVT_RST;
    end
    else if (wrEn)
    begin
      if (adr_i == ADR_SYSCTL)
        ctrl_r.nmiEdge <= dat_i[0];
      else if (adr_i == ADR_SENSE)
        ctrl_r.sense <= dat_i[5:0];
      else if (adr_i == ADR_ENABLE)
        ctrl_r.enable <= dat_i[5:0];
      else if (adr_i == ADR_PRIO)
        ctrl_r.prio <= dat_i[PRIO_MSB:PRIO_LSB];
      else if (adr_i == ADR_EVTMASK)
        evtMask_r <= dat_i[7:0];
    end
  end

  // ----------------------------------------
  // maskable request detection
  // ----------------------------------------
  logic [NUM_IRQ-1:0] setVec;
  logic [NUM_IRQ-1:0] clrVec;
  logic [NUM_IRQ-1:0] fallHit;
  logic [NUM_IRQ-1:0] levelHit;

  assign fallHit = s3_r[5:0] & ~s2_r[5:0] & {NUM_IRQ{primed}};
  assign levelHit = ~s2_r[5:0];
  assign setVec = (ctrl_r.sense & fallHit) | (~ctrl_r.sense & levelHit);
  assign clrVec = (wrEn && adr_i == ADR_FLAGS) ? ~dat_i[5:0] : 6'h00;

  always_ff @(posedge clk)
  begin
    if (srst)
      flags_r <= 6'h00;
    else
      flags_r <= (flags_r & ~clrVec) | setVec;
  end

  assign irqReq = flags_r & ctrl_r.enable & {NUM_IRQ{~intMaskBit}};
  assign irqPriority = ctrl_r.prio;

  // ----------------------------------------
  // non-maskable request
  // ----------------------------------------
  logic nmiHit;
  logic nmiPending_r;
  logic [7:0] nmiVector_r;
  logic wakeUp_r;

  assign nmiHit = primed &
    (ctrl_r.nmiEdge ? (s2_r[6] & ~s3_r[6]) : (s3_r[6] & ~s2_r[6]));

  always_ff @(posedge clk)
  begin
    if (srst)
      nmiPending_r <= 1'b0;
    else
      nmiPending_r <= (nmiPending_r & ~nmiAck) | nmiHit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      nmiVector_r <= 8'h00;
    else
      nmiVector_r <= NMI_VECTOR;
  end

  assign nmiReq = nmiPending_r;
  assign nmiVector = nmiVector_r;

  // ----------------------------------------
  // standby wake-up
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      wakeUp_r <= 1'b0;
    else
      wakeUp_r <= standbyIn & (nmiHit | (|(setVec & WAKE_CAPABLE)));
  end

  assign wakeUp = wakeUp_r;

  // ----------------------------------------
  // event status and interrupt output
  // ----------------------------------------
  logic [7:0] evtSet;
  logic [7:0] evtClr;

  assign evtSet = {wakeUp_r, nmiHit, setVec};
  assign evtClr = (wrEn && adr_i == ADR_EVT) ? dat_i[7:0] : 8'h00;

  always_ff @(posedge clk)
  begin
    if (srst)
      evt_r <= EVT_RST;
    else
      evt_r <= (evt_r & ~evtClr) | evtSet;
  end

  assign intOut = |(evt_r & evtMask_r);

  // ----------------------------------------
  // assertions: non-maskable request
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_NMI_RISE: assert property (primed && ctrl_r.nmiEdge && s2_r[6] && !s3_r[6]
    |=> nmiReq)
    else $error("rising edge on nmi input not taken");
  AST_NMI_FALL: assert property (primed && !ctrl_r.nmiEdge && !s2_r[6] && s3_r[6]
    |=> nmiReq)
    else $error("falling edge on nmi input not taken");
  AST_NMI_EARLY: assert property (!primed |=> !nmiReq)
    else $error("nmi raised before the synchroniser held a real sample");
  AST_NMI_NOMASK: assert property (nmiReq && !nmiAck && intMaskBit |=> nmiReq)
    else $error("nmi request dropped by the mask bit");
  AST_NMI_ACK: assert property (nmiReq && nmiAck && !nmiHit |=> !nmiReq)
    else $error("nmi request not cleared by the acknowledge");
  AST_NMI_VEC: assert property (nmiReq |-> nmiVector == 8'h07)
    else $error("nmi vector is not 7");

  // ----------------------------------------
  // assertions: standby wake-up
  // ----------------------------------------
  AST_WAKE: assert property (standbyIn && nmiHit |=> wakeUp)
    else $error("nmi did not wake from standby");
  AST_WAKE_IRQ: assert property (standbyIn && setVec[2] |=> wakeUp)
    else $error("request two did not wake from standby");
  AST_NOWAKE: assert property (standbyIn && !nmiHit && (setVec & 6'h07) == 6'h00
    |=> !wakeUp)
    else $error("wake raised by a request without wake capability");
  AST_NO_STANDBY: assert property (!standbyIn |=> !wakeUp)
    else $error("wake raised outside standby");

  // ----------------------------------------
  // assertions: maskable requests
  // ----------------------------------------
  AST_SET: assert property (##1 ((flags_r & $past(setVec)) == $past(setVec)))
    else $error("detected request did not set its flag");
  AST_FALL_EDGE: assert property (primed && ctrl_r.sense[0] && s3_r[0] && !s2_r[0]
    |=> flags_r[0])
    else $error("falling edge on request zero not flagged");
  AST_LEVEL: assert property (!ctrl_r.sense[4] && !s2_r[4] |=> flags_r[4])
    else $error("low level on request four not flagged");
  AST_ENABLE: assert property ((irqReq & ~ctrl_r.enable) == 6'h00)
    else $error("disabled request delivered");
  AST_IRQ_PASS: assert property (flags_r[0] && ctrl_r.enable[0] && !intMaskBit
    |-> irqReq[0])
    else $error("enabled request not delivered");
  AST_IRQ_MASK: assert property (intMaskBit |-> irqReq == 6'h00)
    else $error("request delivered while the mask bit is set");
  AST_PRIO: assert property (wrEn && adr_i == ADR_PRIO
    |=> irqPriority == $past(dat_i[7:4]))
    else $error("priority bits not taken from bits 7 to 4");
  AST_CLR: assert property (wrEn && adr_i == ADR_FLAGS && !dat_i[0] && !setVec[0]
    |=> !flags_r[0])
    else $error("writing 0 did not clear the flag");
  AST_CLR_ONE: assert property (wrEn && adr_i == ADR_FLAGS && dat_i[1] && flags_r[1]
    |=> flags_r[1])
    else $error("writing 1 cleared the flag");
  AST_HOLD: assert property (flags_r[0] && !clrVec[0] |=> flags_r[0])
    else $error("flag dropped without a clear");

  // ----------------------------------------
  // assertions: register bus and events
  // ----------------------------------------
  AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not given in one cycle");
  AST_EVT_CLR: assert property (wrEn && adr_i == ADR_EVT && dat_i[7] && !wakeUp_r
    |=> !evt_r[7])
    else $error("writing 1 did not clear the wake event");
  AST_INT_LEVEL: assert property (evt_r[7] && evtMask_r[7] |-> intOut)
    else $error("unmasked event did not raise the interrupt output");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  COV_NMI: cover property (nmiHit ##1 nmiReq ##[1:20] nmiAck);
  COV_WAKE: cover property (standbyIn && wakeUp);
  COV_CLR: cover property (flags_r[1] ##1 !flags_r[1]);
  COV_READ: cover property (rdEn && adr_i == ADR_FLAGS ##1 ack_o);
  COV_LEVEL: cover property (!ctrl_r.sense[4] && !s2_r[4] ##1 flags_r[4]);

endmodule
`default_nettype wire

/* File: hw/ext_irq_pkg.sv */
// constants and types of the external interrupt request block
// What this block does
// - seven external requests: one non-maskable input and six active-low pins five to zero
// - non-maskable request has top priority and ignores the processor mask bits
// - one edge-select bit picks rising or falling edge for the non-maskable input
// - the non-maskable request is handled with exception vector number 7
// - non-maskable and requests zero to two wake from software standby, three to five not
// - each maskable pin senses either a low level or a falling edge
// - an enable bit per maskable request allows or blocks its delivery
// - maskable request priority is set by bits 7 to 4 of priority register A
// - a status flag per maskable pin records a request; software clears it by writing 0
package ext_irq_pkg;
  localparam int NUM_IRQ = 6;
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_SYSCTL = 8'h00;
  localparam logic [7:0] ADR_SENSE = 8'h04;
  localparam logic [7:0] ADR_ENABLE = 8'h08;
  localparam logic [7:0] ADR_FLAGS = 8'h0C;
  localparam logic [7:0] ADR_PRIO = 8'h10;
  localparam logic [7:0] ADR_EVT = 8'h14;
  localparam logic [7:0] ADR_EVTMASK = 8'h18;
  localparam int PRIO_LSB = 4;
  localparam int PRIO_MSB = 7;
  localparam int EVT_NMI = 6;
  localparam int EVT_WAKE = 7;
  localparam logic [7:0] NMI_VECTOR = 8'h07;
  localparam logic [5:0] WAKE_CAPABLE = 6'h07;
  localparam logic [6:0] SYNC_RST = 7'h7F;
  localparam logic [5:0] SENSE_RST = 6'h00;
  localparam logic [5:0] ENABLE_RST = 6'h00;
  localparam logic NMI_EDGE_RST = 1'b0;
  localparam logic [3:0] PRIO_RST = 4'h0;
  localparam logic [7:0] EVT_RST = 8'h00;

  typedef struct packed {
    logic nmiEdge;
    logic [5:0] sense;
    logic [5:0] enable;
    logic [3:0] prio;
  } ctrl_t;
endpackage

/* File: dv/irq_pin_partner.sv */
// pin-side partner: request sources and the core's nmi acknowledge
`timescale 1ns/1ns
`default_nettype none
module irq_pin_partner
(
  input wire logic clk,
  input wire logic nmiReq,
  input wire logic nmiDrive,
  input wire logic [5:0] irqDrive_n,
  output logic nmiPin,
  output logic [5:0] irqPin_n,
  output logic nmiAck
);
  initial
  begin
    nmiPin = 1'b0;
    irqPin_n = 6'h3F;
    nmiAck = 1'b0;
  end
  always @(posedge clk)
  begin
    nmiPin <= nmiDrive;
    irqPin_n <= irqDrive_n;
    nmiAck <= nmiReq & ~nmiAck;
  end
endmodule
`default_nettype wire

/* File: dv/tb_external_interrupt_sources.sv */
// self-checking bench of the external interrupt request block
`timescale 1ns/1ns
`default_nettype none
module tb_external_interrupt_sources;
  import ext_irq_pkg::*;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datW = 32'h0, datR, q;
  logic [3:0] sel = 4'hF;
  logic ack, nmiPin, intMaskBit = 1'b0, standbyIn = 1'b0, nmiAck, nmiReq, wakeUp, intOut;
  logic nmiDrive = 1'b0;
  logic [5:0] irqDrive_n = 6'h3F, irqPin_n, irqReq;
  logic [7:0] nmiVector;
  logic [3:0] irqPriority;
  int failures = 0, cmp_count = 0, wakeCount = 0;
  always #50 clk = ~clk;
  always @(posedge clk)
    if (wakeUp === 1'b1)
      wakeCount <= wakeCount + 1;
  external_interrupt_sources uut (.clk(clk), .srst(srst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(datW), .sel_i(sel), .dat_o(datR), .ack_o(ack),
    .nmiPin(nmiPin), .irqPin_n(irqPin_n), .intMaskBit(intMaskBit), .standbyIn(standbyIn),
    .nmiAck(nmiAck), .nmiReq(nmiReq), .nmiVector(nmiVector), .irqReq(irqReq),
    .irqPriority(irqPriority), .wakeUp(wakeUp), .intOut(intOut));
  irq_pin_partner peer (.clk(clk), .nmiReq(nmiReq), .nmiDrive(nmiDrive),
    .irqDrive_n(irqDrive_n), .nmiPin(nmiPin), .irqPin_n(irqPin_n), .nmiAck(nmiAck));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    @(posedge clk iff ack === 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [5:0] n);
    irqDrive_n <= n;
    repeat (4) @(posedge clk);
    irqDrive_n <= 6'h3F;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset();
    chk(nmiVector, 32'h07);
    wb(1'b0, ADR_PRIO, 32'h0);
    chk(q, 32'h00);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h00);
    wb(1'b1, ADR_PRIO, 32'hA0);
    chk(irqPriority, 32'hA);
  endtask
  task automatic t_nmi();
    intMaskBit <= 1'b1;
    wb(1'b1, ADR_SYSCTL, 32'h1);
    nmiDrive <= 1'b1;
    @(posedge clk iff nmiReq === 1'b1);
    repeat (4) @(posedge clk);
    chk(nmiReq, 32'h0);
    wb(1'b1, ADR_EVT, 32'hFF);
    nmiDrive <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, ADR_EVT, 32'h0);
    chk(q, 32'h00);
    wb(1'b1, ADR_SYSCTL, 32'h0);
    nmiDrive <= 1'b1;
    repeat (4) @(posedge clk);
    nmiDrive <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, ADR_EVT, 32'h0);
    chk(q, 32'h40);
  endtask
  task automatic t_irq();
    intMaskBit <= 1'b0;
    wb(1'b1, ADR_SENSE, 32'h3F);
    wb(1'b1, ADR_ENABLE, 32'h01);
    pulse(6'h3E);
    chk(irqReq, 32'h01);
    pulse(6'h3D);
    chk(irqReq, 32'h01);
    pulse(6'h3E);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(q, 32'h03);
    intMaskBit <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(irqReq, 32'h00);
    wb(1'b1, ADR_FLAGS, 32'hFE);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(q, 32'h02);
  endtask
  task automatic t_wake();
    wb(1'b1, ADR_EVT, 32'hFF);
    wb(1'b1, ADR_EVTMASK, 32'h80);
    standbyIn <= 1'b1;
    pulse(6'h37);
    chk(intOut, 32'h0);
    chk(wakeCount, 32'h0);
    pulse(6'h3B);
    chk(intOut, 32'h1);
    chk(wakeCount, 32'h1);
    wb(1'b1, ADR_EVT, 32'h80);
    chk(intOut, 32'h0);
    standbyIn <= 1'b0;
  endtask
  task automatic t_level();
    wb(1'b1, ADR_SENSE, 32'h00);
    irqDrive_n <= 6'h2F;
    repeat (6) @(posedge clk);
    wb(1'b1, ADR_FLAGS, 32'h00);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(q, 32'h10);
    irqDrive_n <= 6'h3F;
    repeat (6) @(posedge clk);
    wb(1'b1, ADR_FLAGS, 32'h00);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(q, 32'h00);
  endtask
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_nmi();
    t_irq();
    t_wake();
    t_level();
    end_of_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
